// ==== inc/srpc_map.svh ====
`ifndef SRPC_MAP_SVH
`define SRPC_MAP_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SRPC_ADDR_W 13
`define SRPC_DATA_W 16
`define SRPC_DEPTH 8192

// ----------------------------------------
// Command register selectors (address bits 2:0)
// ----------------------------------------
`define SRPC_CMD_START1 3'h0
`define SRPC_CMD_END1 3'h1
`define SRPC_CMD_START2 3'h2
`define SRPC_CMD_END2 3'h3
`define SRPC_CMD_FLOW 3'h4
`define SRPC_CMD_FLAGS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRPC_FLAG1_BIT 0
`define SRPC_FLAG2_BIT 1
`define SRPC_LANE_LO_MSB 7
`define SRPC_LANE_HI_LSB 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRPC_RST_PTR 13'h0000
`define SRPC_RST_START1 13'h0000
`define SRPC_RST_END1 13'h0fff
`define SRPC_RST_START2 13'h1000
`define SRPC_RST_END2 13'h1fff
`define SRPC_RST_FLOW 13'h0000

`endif

// ==== inc/srpc_pkg.sv ====
package srpc_pkg;

    typedef logic [12:0] srpc_addr_t;
    typedef logic [15:0] srpc_word_t;

    // Random port strobes, all active low
    typedef struct packed {
        logic chip_select_n;
        logic command_select_n;
        logic read_write_n;
        logic output_enable_n;
        logic lower_byte_n;
        logic upper_byte_n;
    } srpc_rnd_ctrl_s;

    // Sequential port pins, sampled from the link clock domain
    typedef struct packed {
        logic seq_clock;
        logic seq_reset_n;
        logic seq_chip_select_n;
        logic count_enable_n;
        logic seq_read_write_n;
        logic seq_output_enable_n;
    } srpc_seq_ctrl_s;

endpackage : srpc_pkg

// ==== src/srpc_port_ctrl.sv ====
`timescale 1ns/1ps
`include "srpc_map.svh"

// Notes on behaviour
// - Random read drives only enabled byte lanes
// - Random write stores only enabled byte lanes
// - Both selects high: idle, floated, powered down
// - Output enable high floats, stays powered
// - Both lanes off: no access, no powerdown
// - Command write loads bits 0-12
// - Command read drives bits 0-12
// - Command access allowed per single lane
// - Random decode ignores sequential signals
// - Counted read advances, drives word, flags
// - Uncounted read holds address and flags
// - Output enable high floats, counting continues
// - Sequential write stores word at pointer
// - Counted write at end lowers flag
// - Deselected, uncounted: nothing happens, floated
// - Deselected, counted: advance and flag update
// - Write ends when select or rw high
// - Counter increments before the cycle's access
// - Select registered; retention after registered high
// - Unchanged flag keeps its last value
// - Reset pin clears pointer, flags, select
module srpc_port_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    // Random port
    input wire srpc_pkg::srpc_rnd_ctrl_s rnd_ctrl,
    input wire srpc_pkg::srpc_addr_t rnd_address,
    input wire srpc_pkg::srpc_word_t random_data_in,
    output srpc_pkg::srpc_word_t random_data_out,
    output logic [1:0] random_data_oe,
    output logic rnd_powered_down,
    // Sequential port
    input wire srpc_pkg::srpc_seq_ctrl_s seq_ctrl,
    input wire srpc_pkg::srpc_word_t seq_data_in,
    output srpc_pkg::srpc_word_t seq_data_out,
    output logic seq_data_oe,
    output logic end_flag_one_n,
    output logic end_flag_two_n,
    output logic seq_retention
);

    // ----------------------------------------
    // Shared storage
    // ----------------------------------------
    srpc_pkg::srpc_word_t mem [0:`SRPC_DEPTH-1];

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    srpc_pkg::srpc_rnd_ctrl_s rc_s1_q, rc_q;
    srpc_pkg::srpc_addr_t ra_s1_q, ra_q;
    srpc_pkg::srpc_word_t rd_s1_q, rd_q;
    srpc_pkg::srpc_seq_ctrl_s sc_s1_q, sc_q;
    srpc_pkg::srpc_word_t sd_s1_q, sd_q;
    logic seq_clk_prev_q;

    // Two flops on every pin but rst_n; the second stage feeds logic, as does a third flop on the link clock
    always_ff @(posedge mclk) begin
        rc_s1_q <= rnd_ctrl;
        rc_q <= rc_s1_q;
        ra_s1_q <= rnd_address;
        ra_q <= ra_s1_q;
        rd_s1_q <= random_data_in;
        rd_q <= rd_s1_q;
        sc_s1_q <= seq_ctrl;
        sc_q <= sc_s1_q;
        sd_s1_q <= seq_data_in;
        sd_q <= sd_s1_q;
        seq_clk_prev_q <= sc_q.seq_clock;
    end

    // ----------------------------------------
    // Random port decode
    // ----------------------------------------
    wire rnd_cs = !rc_q.chip_select_n;
    wire rnd_cmd = !rc_q.command_select_n;
    wire rnd_rd = rc_q.read_write_n;
    wire rnd_oe = !rc_q.output_enable_n;
    wire lane_lo = !rc_q.lower_byte_n;
    wire lane_hi = !rc_q.upper_byte_n;
    wire [2:0] cmd_sel = ra_q[2:0];

    // Array and command accesses; no sequential input enters here
    wire mem_rd = rnd_cs && !rnd_cmd && rnd_rd && rnd_oe;
    wire mem_wr = rnd_cs && !rnd_cmd && !rnd_rd;
    wire cmd_rd = !rnd_cs && rnd_cmd && rnd_rd && rnd_oe;
    wire cmd_wr = !rnd_cs && rnd_cmd && !rnd_rd;
    wire [1:0] lanes = {lane_hi, lane_lo};

    // Only driven lanes leave the pins; both lanes off floats all
    assign random_data_oe = (mem_rd || cmd_rd) ? lanes : 2'h0;
    assign rnd_powered_down = !rnd_cs && !rnd_cmd;

    // ----------------------------------------
    // Sequential edge detect and decode
    // ----------------------------------------
    wire seq_edge = sc_q.seq_clock && !seq_clk_prev_q;
    wire pin_reset = !sc_q.seq_reset_n;
    wire s_sel = !sc_q.seq_chip_select_n;
    wire s_cnt = !sc_q.count_enable_n;
    wire s_rd = sc_q.seq_read_write_n;

    // ----------------------------------------
    // Command registers
    // ----------------------------------------
    srpc_pkg::srpc_addr_t start1_q, end1_q, start2_q, end2_q, flow_q;
    srpc_pkg::srpc_addr_t ptr_q;
    logic flag1_n_q, flag2_n_q;
    logic seq_sel_q, seq_rw_q;

    // Byte-lane merge of a 13-bit command field
    function automatic srpc_pkg::srpc_addr_t lane_merge(
        input srpc_pkg::srpc_addr_t old_v,
        input srpc_pkg::srpc_word_t new_v,
        input logic [1:0] en
    );
        srpc_pkg::srpc_addr_t r;
        r = old_v;
        if (en[0]) begin
            r[`SRPC_LANE_LO_MSB:0] = new_v[`SRPC_LANE_LO_MSB:0];
        end
        if (en[1]) begin
            r[12:`SRPC_LANE_HI_LSB] = new_v[12:`SRPC_LANE_HI_LSB];
        end
        return r;
    endfunction : lane_merge

    wire cmd_wr_en = cmd_wr && (lanes != 2'h0);

    // Buffer limits and flow register written from the random port
    always_ff @(posedge mclk) begin
        if (!rst_n || pin_reset) begin
            start1_q <= `SRPC_RST_START1;
            end1_q <= `SRPC_RST_END1;
            start2_q <= `SRPC_RST_START2;
            end2_q <= `SRPC_RST_END2;
            flow_q <= `SRPC_RST_FLOW;
        end else if (cmd_wr_en) begin
            case (cmd_sel)
                `SRPC_CMD_START1: start1_q <= lane_merge(start1_q, rd_q, lanes);
                `SRPC_CMD_END1: end1_q <= lane_merge(end1_q, rd_q, lanes);
                `SRPC_CMD_START2: start2_q <= lane_merge(start2_q, rd_q, lanes);
                `SRPC_CMD_END2: end2_q <= lane_merge(end2_q, rd_q, lanes);
                `SRPC_CMD_FLOW: flow_q <= lane_merge(flow_q, rd_q, lanes);
                default: begin
                end
            endcase
        end
    end

    // Command read value, bits above 12 read zero
    srpc_pkg::srpc_addr_t cmd_val;
    assign cmd_val = (cmd_sel == `SRPC_CMD_START1) ? start1_q :
                     (cmd_sel == `SRPC_CMD_END1) ? end1_q :
                     (cmd_sel == `SRPC_CMD_START2) ? start2_q :
                     (cmd_sel == `SRPC_CMD_END2) ? end2_q :
                     (cmd_sel == `SRPC_CMD_FLOW) ? flow_q :
                     (cmd_sel == `SRPC_CMD_FLAGS) ? {11'h000, flag2_n_q, flag1_n_q} :
                     13'h0000;

    // ----------------------------------------
    // Sequential pointer, chaining between buffers
    // ----------------------------------------
    srpc_pkg::srpc_addr_t ptr_adv;
    assign ptr_adv = (ptr_q == end1_q) ? start2_q :
                     (ptr_q == end2_q) ? start1_q :
                     srpc_pkg::srpc_addr_t'(ptr_q + 13'h0001);

    // Access address is the advanced one when counting
    srpc_pkg::srpc_addr_t seq_addr;
    assign seq_addr = s_cnt ? ptr_adv : ptr_q;

    wire hit1 = s_cnt && (ptr_adv == end1_q);
    wire hit2 = s_cnt && (ptr_adv == end2_q);
    wire clr1 = cmd_wr_en && (cmd_sel == `SRPC_CMD_FLAGS) && lane_lo && rd_q[`SRPC_FLAG1_BIT];
    wire clr2 = cmd_wr_en && (cmd_sel == `SRPC_CMD_FLAGS) && lane_lo && rd_q[`SRPC_FLAG2_BIT];
    wire set1 = seq_edge && hit1;
    wire set2 = seq_edge && hit2;

    // Pointer and registered select advance on link edges only
    always_ff @(posedge mclk) begin
        if (!rst_n || pin_reset) begin
            ptr_q <= `SRPC_RST_PTR;
            seq_sel_q <= 1'b0;
            seq_rw_q <= 1'b0;
        end else if (seq_edge) begin
            if (s_cnt) begin
                ptr_q <= ptr_adv;
            end
            seq_sel_q <= s_sel;
            seq_rw_q <= s_rd;
        end
    end

    // Flags: set by reaching an end, cleared by command; set wins
    always_ff @(posedge mclk) begin
        if (!rst_n || pin_reset) begin
            flag1_n_q <= 1'b1;
            flag2_n_q <= 1'b1;
        end else begin
            if (set1) begin
                flag1_n_q <= 1'b0;
            end else if (clr1) begin
                flag1_n_q <= 1'b1;
            end
            if (set2) begin
                flag2_n_q <= 1'b0;
            end else if (clr2) begin
                flag2_n_q <= 1'b1;
            end
        end
    end

    assign end_flag_one_n = flag1_n_q;
    assign end_flag_two_n = flag2_n_q;
    assign seq_retention = !seq_sel_q;

    // ----------------------------------------
    // Array writes and read data
    // ----------------------------------------
    wire seq_wr = seq_edge && s_sel && !s_rd;

    // Both ports write the shared array; same-cycle collision favours random
    always_ff @(posedge mclk) begin
        if (seq_wr) begin
            mem[seq_addr] <= sd_q;
        end
        if (mem_wr && lane_lo) begin
            mem[ra_q][`SRPC_LANE_LO_MSB:0] <= rd_q[`SRPC_LANE_LO_MSB:0];
        end
        if (mem_wr && lane_hi) begin
            mem[ra_q][15:`SRPC_LANE_HI_LSB] <= rd_q[15:`SRPC_LANE_HI_LSB];
        end
    end

    srpc_pkg::srpc_word_t rnd_out_q, seq_out_q;

    // Random read word, refreshed every cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rnd_out_q <= 16'h0000;
        end else begin
            rnd_out_q <= cmd_rd ? {3'h0, cmd_val} : mem[ra_q];
        end
    end

    // Sequential read word, captured on each selected read edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seq_out_q <= 16'h0000;
        end else if (seq_edge && s_sel && s_rd) begin
            seq_out_q <= mem[seq_addr];
        end
    end

    assign random_data_out = rnd_out_q;
    assign seq_data_out = seq_out_q;
    // Drive only after a registered selected read with output enable low
    assign seq_data_oe = seq_sel_q && seq_rw_q && !sc_q.seq_output_enable_n;

endmodule : srpc_port_ctrl

// ==== verification/srpc_port_ctrl_monitor.sv ====
`timescale 1ns/1ps
module srpc_port_ctrl_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire srpc_pkg::srpc_rnd_ctrl_s rnd_ctrl,
    input wire logic [1:0] random_data_oe,
    input wire logic rnd_powered_down,
    input wire srpc_pkg::srpc_seq_ctrl_s seq_ctrl,
    input wire logic seq_data_oe,
    input wire logic end_flag_one_n,
    input wire logic seq_retention
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic clk_q;
    logic [3:0] since_q;
    logic [3:0] since_d;
    // Cycles since the link clock pin rose or the reset pin was low, saturating
    assign since_d = ((seq_ctrl.seq_clock && !clk_q) || !seq_ctrl.seq_reset_n) ? 4'h0 :
                     since_q + {3'h0, since_q != 4'hf};
    always_ff @(posedge mclk) begin
        clk_q <= seq_ctrl.seq_clock;
        since_q <= rst_n ? since_d : 4'hf;
    end
    property p_idle;
        (rnd_ctrl.chip_select_n && rnd_ctrl.command_select_n) [*4]
            |-> rnd_powered_down && random_data_oe == 2'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle port not floated");
    property p_read_lanes;
        (rnd_ctrl[5:2] == 4'h6 && $stable(rnd_ctrl)) [*4]
            |-> random_data_oe == ~{rnd_ctrl.upper_byte_n, rnd_ctrl.lower_byte_n};
    endproperty
    a_read_lanes: assert property (p_read_lanes) else $error("read lanes wrong");
    property p_cmd_lanes;
        (rnd_ctrl[5:2] == 4'ha && $stable(rnd_ctrl)) [*4]
            |-> random_data_oe == ~{rnd_ctrl.upper_byte_n, rnd_ctrl.lower_byte_n};
    endproperty
    a_cmd_lanes: assert property (p_cmd_lanes) else $error("command lanes wrong");
    property p_no_lanes;
        (!rnd_ctrl.chip_select_n && rnd_ctrl.lower_byte_n && rnd_ctrl.upper_byte_n) [*4]
            |-> !rnd_powered_down && random_data_oe == 2'h0;
    endproperty
    a_no_lanes: assert property (p_no_lanes) else $error("lane-less access wrong");
    property p_retain_float;
        seq_retention |-> !seq_data_oe;
    endproperty
    a_retain_float: assert property (p_retain_float) else $error("bus driven in retention");
    property p_retain_edge;
        $changed(seq_retention) |-> since_q <= 4'h7;
    endproperty
    a_retain_edge: assert property (p_retain_edge) else $error("select not clocked");
    property p_flag_fall;
        $fell(end_flag_one_n) |-> since_q <= 4'h7;
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell off clock");
    property p_reset_state;
        $rose(rst_n) |-> end_flag_one_n && seq_retention && !seq_data_oe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule : srpc_port_ctrl_monitor

// ==== verification/srpc_seq_master.sv ====
`timescale 1ns/1ps
// Sequential port master: one link clock period per call, clock idle low
module srpc_seq_master (
    output srpc_pkg::srpc_seq_ctrl_s seq_ctrl,
    output srpc_pkg::srpc_word_t seq_data_in
);
    initial begin
        seq_ctrl = 6'h1f;
        seq_data_in = 16'h5a5a;
    end
    // p is {select_n, count_n, rw_n, output_enable_n}
    task automatic cycle(input logic [3:0] p, input srpc_pkg::srpc_word_t d);
        seq_ctrl[4:0] = {1'b1, p};
        seq_data_in = p[1] ? ~d : d;
        #160;
        seq_ctrl.seq_clock = 1'b1;
        #160;
        seq_ctrl.seq_clock = 1'b0;
        seq_data_in = ~seq_data_in; // Released bus does not keep its value
    endtask : cycle
    // Pulses the reset pin low for four system clocks; the link clock stays idle
    task automatic pulse_reset();
        seq_ctrl.seq_reset_n = 1'b0;
        #160;
        seq_ctrl.seq_reset_n = 1'b1;
        #160;
    endtask : pulse_reset
endmodule : srpc_seq_master

// ==== verification/srpc_port_ctrl_test.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module srpc_port_ctrl_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    srpc_pkg::srpc_rnd_ctrl_s rnd_ctrl = 6'h3f;
    srpc_pkg::srpc_addr_t rnd_address = 13'h0000;
    srpc_pkg::srpc_word_t random_data_in = 16'h0000;
    srpc_pkg::srpc_word_t random_data_out, seq_data_out, seq_data_in, rd_word, d, d2;
    srpc_pkg::srpc_seq_ctrl_s seq_ctrl;
    srpc_pkg::srpc_word_t shadow [1:4];
    logic [1:0] random_data_oe, rd_oe, ln;
    logic rnd_powered_down, seq_data_oe, end_flag_one_n, end_flag_two_n, seq_retention;
    logic rd_pd;
    logic [31:0] seed = 32'h00016646;
    logic [31:0] r;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    srpc_port_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .rnd_ctrl(rnd_ctrl),
        .rnd_address(rnd_address), .random_data_in(random_data_in),
        .random_data_out(random_data_out), .random_data_oe(random_data_oe),
        .rnd_powered_down(rnd_powered_down), .seq_ctrl(seq_ctrl), .seq_data_in(seq_data_in),
        .seq_data_out(seq_data_out), .seq_data_oe(seq_data_oe), .end_flag_one_n(end_flag_one_n),
        .end_flag_two_n(end_flag_two_n), .seq_retention(seq_retention));
    srpc_seq_master u_seq (.seq_ctrl(seq_ctrl), .seq_data_in(seq_data_in));
    always #20 mclk = ~mclk;
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    // Word after a lane-masked write; en_n is {upper, lower}, active low
    function automatic srpc_pkg::srpc_word_t merge(input srpc_pkg::srpc_word_t o, n,
            input logic [1:0] en_n);
        return {en_n[1] ? o[15:8] : n[15:8], en_n[0] ? o[7:0] : n[7:0]};
    endfunction : merge
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic do_reset();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
    endtask : do_reset
    // Random access: c is {cs, cmd, rw, oe, lower, upper}; idle keeps command high
    task automatic rnd_op(input logic [5:0] c, input srpc_pkg::srpc_addr_t a,
            input srpc_pkg::srpc_word_t w);
        @(negedge mclk);
        rnd_ctrl = c;
        rnd_address = a;
        random_data_in = w;
        repeat (5) @(negedge mclk);
        rd_word = random_data_out;
        rd_oe = random_data_oe;
        rd_pd = rnd_powered_down;
        rnd_ctrl = 6'h3f;
        repeat (3) @(negedge mclk);
    endtask : rnd_op
    task automatic seq_op(input logic [3:0] p, input srpc_pkg::srpc_word_t w);
        @(negedge mclk);
        u_seq.cycle(p, w);
        repeat (4) @(negedge mclk);
    endtask : seq_op
    initial begin
        do_reset();
        // Lane-masked writes and reads at random places, every lane mask
        for (int i = 0; i < 8; i++) begin
            r = xorshift();
            d = r[15:0];
            ln = i[1:0];
            d2 = 16'(xorshift() >> 8);
            rnd_op(6'h14, r[28:16], d);
            rnd_op({4'h5, ln}, r[28:16], d2);
            rnd_op({4'h6, ln}, r[28:16], 16'h0000);
            `CHK(rd_oe, ~{ln[0], ln[1]})
            rnd_op(6'h18, r[28:16], 16'h0000);
            `CHK(rd_word, merge(d, d2, {ln[0], ln[1]}))
            rnd_op(6'h1c, r[28:16], 16'h0000);
            `CHK(rd_oe, 2'h0)
            `CHK(rd_pd, 1'b0)
            `CHK(rnd_powered_down, 1'b1)
        end
        // Command register, whole word then low lane only
        r = xorshift();
        rnd_op(6'h24, 13'h0003, {3'h0, r[12:0]});
        rnd_op(6'h28, 13'h0003, 16'h0000);
        `CHK(rd_word, {3'h0, r[12:0]})
        rnd_op(6'h25, 13'h0003, r[31:16]);
        rnd_op(6'h29, 13'h0003, 16'h0000);
        `CHK(rd_word[12:0], {r[12:8], r[23:16]})
        `CHK(rd_oe, 2'h1)
        // Counted writes up to a short buffer end, then an uncounted rewrite
        do_reset();
        rnd_op(6'h24, 13'h0001, 16'h0004);
        for (int k = 1; k <= 4; k++) begin
            r = xorshift();
            shadow[k] = r[15:0];
            seq_op(4'h1, r[15:0]);
        end
        `CHK(end_flag_one_n, 1'b0)
        r = xorshift();
        shadow[4] = r[15:0];
        seq_op(4'h5, r[15:0]);
        `CHK(end_flag_one_n, 1'b0)
        // Flag status read, then clear of flag one through the low lane
        rnd_op(6'h28, 13'h0005, 16'h0000);
        `CHK(rd_word, 16'h0002)
        rnd_op(6'h25, 13'h0005, 16'h0001);
        `CHK(end_flag_one_n, 1'b1)
        for (int k = 1; k <= 4; k++) begin
            rnd_op(6'h18, 13'(k), 16'h0000);
            `CHK(rd_word, shadow[k])
        end
        // Sequential reads after a reset pin pulse: counted, held, deselected, floated
        @(negedge mclk);
        u_seq.pulse_reset();
        repeat (4) @(negedge mclk);
        `CHK({end_flag_one_n, end_flag_two_n, seq_retention}, 3'h7)
        seq_op(4'h2, 16'h0000);
        `CHK(seq_data_out, shadow[1])
        `CHK(seq_data_oe, 1'b1)
        seq_op(4'h6, 16'h0000);
        `CHK(seq_data_out, shadow[1])
        seq_op(4'ha, 16'h0000);
        `CHK(seq_data_oe, 1'b0)
        seq_op(4'h3, 16'h0000);
        `CHK(seq_data_oe, 1'b0)
        seq_op(4'h2, 16'h0000);
        `CHK(seq_data_out, shadow[4])
        tally_and_finish();
    end
endmodule : srpc_port_ctrl_test
bind srpc_port_ctrl srpc_port_ctrl_monitor u_mon (.mclk(mclk), .rst_n(rst_n),
    .rnd_ctrl(rnd_ctrl), .random_data_oe(random_data_oe), .rnd_powered_down(rnd_powered_down),
    .seq_ctrl(seq_ctrl), .seq_data_oe(seq_data_oe), .end_flag_one_n(end_flag_one_n),
    .seq_retention(seq_retention));
